// *** logic/uart_pkg.sv ***
// package: register map, field positions, reset values, timing and mode codes for the serial port
package uart_pkg;
  // register byte addresses on the axi4-lite bus
  localparam logic [7:0] CTRL_OFFS  = 8'h00;  // serial_control
  localparam logic [7:0] BUF_OFFS   = 8'h04;  // serial_buffer
  localparam logic [7:0] ADDR_OFFS  = 8'h08;  // own_address
  localparam logic [7:0] MASK_OFFS  = 8'h0c;  // address_mask
  localparam logic [7:0] PWR_OFFS   = 8'h10;  // power_control_reg
  localparam logic [7:0] STAT_OFFS  = 8'h14;  // frame error view, busy bits

  // serial control field positions
  localparam int CTL_HI  = 7;
  localparam int CTL_LO  = 6;
  localparam int CTL_MP  = 5;
  localparam int CTL_REN = 4;
  localparam int CTL_TB8 = 3;
  localparam int CTL_RB8 = 2;
  localparam int CTL_TI  = 1;
  localparam int CTL_RI  = 0;
  // power control field positions
  localparam int PWR_DBL = 7;
  localparam int PWR_EVS = 6;

  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] ADDR_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;

  // oscillator fractions and oversampling
  localparam int SHIFT_DIV = 12;  // mode 0 bit time in clocks
  localparam int M2_DIV    = 64;  // mode 2 bit time, halved by doubler
  localparam int OVS       = 16;  // receiver samples per bit

  typedef enum logic [1:0] {
    MODE_SHIFT = 2'b00,
    MODE_8BIT  = 2'b01,
    MODE_9FIX  = 2'b10,
    MODE_9VAR  = 2'b11
  } mode_e;
endpackage

// *** logic/uart_addr_recog_ctrl.sv ***
// serial port with four modes, frame error detection and masked address recognition
//
// Contract
// R01: mode 3 sends the 11-bit mode 2 frame at the variable rate.
// R02: a write to the serial buffer starts a transmission in every mode; the code ignores a write made while the transmitter is busy.
// R03: mode 0 receives whenever receive-done is clear and receive enable set; the code also waits until the transmitter is idle.
// R04: modes 1-3 start receiving on a falling start edge with receive enable set.
// R05: bad stop bit sets frame error; only a software write clears it.
// R06: control bit 7 shows frame error if error view set, else mode high bit.
// R07: mode bits 00,01,10,11 select modes 0,1,2,3.
// R08: modes 2/3 multiprocessor: receive-done only for ninth bit 1 and address match.
// R09: mode 1 multiprocessor: receive-done only for valid stop and address match.
// R10: receive enable 1 permits reception, 0 inhibits it.
// R11: modes 2/3 transmit the tx ninth bit as data bit nine.
// R12: modes 2/3 store the received ninth bit in the rx ninth-bit field.
// R13: transmit-done set when a frame has been sent.
// R14: receive-done set when a frame completes, subject to address filtering.
// R15: compare pattern uses own address where mask is 1, don't care where 0.
// R16: own address and address mask are readable and writable.
// R17: multiprocessor: receive-done needs masked match and ninth bit 1; the code also accepts the all-ones broadcast byte without a masked match.
// R18: address recognition acts in modes 1-3, never in mode 0.
// R19: mode 0 shifts lsb first on rx line, clock on tx line at osc/12.
// R20: mode 1 frame is start 0, eight data, stop 1; stop kept in rx ninth bit.
// R21: mode 2 runs at osc/64, or osc/32 with the baud doubler.
// R22: interrupt is or of done flags; only software clears them.
// R23: modes 1 and 3 take their rate from an external baud tick input.
// R24: receiver oversamples 16x, votes three centre samples, rejects false starts.
`timescale 1ns/10ps
module uart_addr_recog_ctrl (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        baud_tick,
  input  wire logic        rxd_in,
  output logic             rxd_out,
  output logic             rxd_oe,
  output logic             txd_out,
  output logic             serial_irq
);
  // register state
  logic [1:0]  mode_r;
  logic        fe_r, mp_r, ren_r, tb8_r, rb8_r, ti_r, ri_r;
  logic        dbl_r, evs_r;
  logic [7:0]  own_address_r, address_mask_r, rx_buf_r;
  // bus state
  logic [7:0]  aw_addr_r, w_data_r;
  logic        aw_have_r, w_have_r, w_lane_r;
  logic        wr_fire, rd_fire;
  logic [7:0]  rd_val;
  logic        aw_ok;

  // events from the serial engines
  logic        tx_done, rx_done, rx_fe_set;
  logic        rx_ninth;
  logic [7:0]  rx_byte;
  logic        tx_busy_r, rx_busy_r;

  // write address and data are taken independently, then committed together
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r  <= 8'h00;
      w_lane_r  <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_r <= 1'b1;
        w_data_r <= s_axi_wdata[7:0];
        w_lane_r <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        aw_have_r <= 1'b0;
        w_have_r  <= 1'b0;
      end
    end
  end

  assign s_axi_awready = aresetn && !aw_have_r && !s_axi_bvalid;
  assign s_axi_wready  = aresetn && !w_have_r && !s_axi_bvalid;
  assign wr_fire       = aw_have_r && w_have_r && !s_axi_bvalid;
  // byte lane 0 carries every register; other lanes are ignored
  wire   wr_en         = wr_fire && w_lane_r;
  assign aw_ok = (aw_addr_r[7:2] <= uart_pkg::STAT_OFFS[7:2]) && (aw_addr_r[1:0] == 2'b00);

  // write response; unmapped addresses answer slverr
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= aw_ok ? 2'b00 : 2'b10;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  wire ctrl_wr = wr_en && aw_addr_r == uart_pkg::CTRL_OFFS;
  wire buf_wr  = wr_en && aw_addr_r == uart_pkg::BUF_OFFS;

  // control fields; hardware set wins over a software clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {fe_r, mode_r, mp_r, ren_r, tb8_r, rb8_r, ti_r, ri_r} <= {1'b0, uart_pkg::CTRL_RST};
    end else begin
      if (ctrl_wr) begin
        if (evs_r) fe_r <= w_data_r[uart_pkg::CTL_HI];  // R06
        else mode_r[1] <= w_data_r[uart_pkg::CTL_HI];  // R07
        mode_r[0] <= w_data_r[uart_pkg::CTL_LO];  // R07
        mp_r      <= w_data_r[uart_pkg::CTL_MP];
        ren_r     <= w_data_r[uart_pkg::CTL_REN];  // R10
        tb8_r     <= w_data_r[uart_pkg::CTL_TB8];
        rb8_r     <= w_data_r[uart_pkg::CTL_RB8];
        ti_r      <= w_data_r[uart_pkg::CTL_TI];
        ri_r      <= w_data_r[uart_pkg::CTL_RI];
      end
      if (rx_fe_set) fe_r <= 1'b1;  // R05
      if (tx_done) ti_r <= 1'b1;  // R13
      if (rx_done) begin
        ri_r     <= 1'b1;  // R14
        rx_buf_r <= rx_byte;
        if (mode_r != uart_pkg::MODE_SHIFT) rb8_r <= rx_ninth;  // R12 R20
      end
    end
  end

  // power control, address and mask registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dbl_r          <= 1'b0;
      evs_r          <= 1'b0;
      own_address_r  <= uart_pkg::ADDR_RST;
      address_mask_r <= uart_pkg::MASK_RST;
    end else if (wr_en) begin
      if (aw_addr_r == uart_pkg::PWR_OFFS) begin
        dbl_r <= w_data_r[uart_pkg::PWR_DBL];
        evs_r <= w_data_r[uart_pkg::PWR_EVS];
      end
      if (aw_addr_r == uart_pkg::ADDR_OFFS) own_address_r <= w_data_r;  // R16
      if (aw_addr_r == uart_pkg::MASK_OFFS) address_mask_r <= w_data_r;  // R16
    end
  end

  // read mux
  always_comb begin
    rd_val = 8'h00;
    case (s_axi_araddr)
      uart_pkg::CTRL_OFFS: rd_val = {evs_r ? fe_r : mode_r[1], mode_r[0], mp_r, ren_r,
                                     tb8_r, rb8_r, ti_r, ri_r};  // R06
      uart_pkg::BUF_OFFS:  rd_val = rx_buf_r;
      uart_pkg::ADDR_OFFS: rd_val = own_address_r;
      uart_pkg::MASK_OFFS: rd_val = address_mask_r;
      uart_pkg::PWR_OFFS:  rd_val = {dbl_r, evs_r, 6'h00};
      uart_pkg::STAT_OFFS: rd_val = {5'h00, rx_busy_r, tx_busy_r, fe_r};
      default:             rd_val = 8'h00;
    endcase
  end

  assign s_axi_arready = aresetn && !s_axi_rvalid;
  assign rd_fire       = s_axi_arvalid && s_axi_arready;

  // read data channel, one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'b00;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h00_0000, rd_val};
      s_axi_rresp  <= (s_axi_araddr[7:2] <= uart_pkg::STAT_OFFS[7:2] && s_axi_araddr[1:0] == 2'b00)
                      ? 2'b00 : 2'b10;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // bit-rate enables: mode 0 at osc/12, mode 2 at osc/64 or /32, others from baud_tick
  logic [5:0] div_r;
  logic       bit_en;
  wire  [5:0] div_top = (mode_r == uart_pkg::MODE_SHIFT) ? 6'(uart_pkg::SHIFT_DIV - 1)
                      : dbl_r ? 6'(uart_pkg::M2_DIV / 2 - 1) : 6'(uart_pkg::M2_DIV - 1);  // R19 R21
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_r  <= 6'h00;
      bit_en <= 1'b0;
    end else begin
      // bit_en marks the cycle in which the mode 0 shift clock rises
      bit_en <= (div_r == 6'(uart_pkg::SHIFT_DIV / 2 - 1));
      div_r  <= (div_r >= div_top) ? 6'h00 : div_r + 6'h01;
    end
  end
  // async tick for modes 1-3 is 16x the bit rate; mode 2 divides its fraction by 16
  wire  os_tick = (mode_r == uart_pkg::MODE_9FIX) ? (dbl_r ? div_r[0] : (div_r[1:0] == 2'b11))
                : baud_tick;  // R01 R21 R23

  // transmitter: shift register with frame length by mode
  logic [10:0] tx_sh_r;
  logic [3:0]  tx_cnt_r, tx_os_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_busy_r <= 1'b0;
      tx_sh_r   <= 11'h7ff;
      tx_cnt_r  <= 4'h0;
      tx_os_r   <= 4'h0;
      txd_out   <= 1'b1;
      tx_done   <= 1'b0;
    end else begin
      tx_done  <= 1'b0;
      if (buf_wr && !tx_busy_r) begin  // R02
        tx_busy_r <= 1'b1;
        tx_os_r   <= 4'h0;
        if (mode_r == uart_pkg::MODE_SHIFT) begin
          tx_sh_r  <= {3'h7, w_data_r};
          tx_cnt_r <= 4'd8;
        end else if (mode_r == uart_pkg::MODE_8BIT) begin
          tx_sh_r  <= {2'b11, w_data_r, 1'b0};  // R20
          tx_cnt_r <= 4'd10;
        end else begin
          tx_sh_r  <= {1'b1, tb8_r, w_data_r, 1'b0};  // R11 R01
          tx_cnt_r <= 4'd11;
        end
      end else if ((tx_busy_r || rx_busy_r) && mode_r == uart_pkg::MODE_SHIFT) begin
        // clock on the tx line in either direction: low in first half, data taken on rising
        if (div_r == 6'd0) txd_out <= 1'b0;  // R19
        if (div_r == 6'd6) txd_out <= 1'b1;
        // shift only on a rise that followed a low half, so the first bit is never skipped
        if (tx_busy_r && bit_en && !txd_out) begin
          tx_sh_r  <= {1'b1, tx_sh_r[10:1]};
          tx_cnt_r <= tx_cnt_r - 4'h1;
          if (tx_cnt_r == 4'h1) begin
            tx_busy_r <= 1'b0;
            tx_done   <= 1'b1;  // R13
          end
        end
      end else if (tx_busy_r && os_tick) begin
        txd_out <= tx_sh_r[0];
        tx_os_r <= tx_os_r + 4'h1;
        if (tx_os_r == 4'hf) begin
          tx_sh_r  <= {1'b1, tx_sh_r[10:1]};
          tx_cnt_r <= tx_cnt_r - 4'h1;
          if (tx_cnt_r == 4'h1) begin
            tx_busy_r <= 1'b0;
            tx_done   <= 1'b1;  // R13
          end
        end
      end else if (!tx_busy_r) begin
        txd_out <= 1'b1;
      end
    end
  end

  // mode 0 data leaves on the rx line, lsb first
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rxd_out <= 1'b1;
      rxd_oe  <= 1'b0;
    end else begin
      rxd_out <= tx_sh_r[0];  // R19
      rxd_oe  <= tx_busy_r && mode_r == uart_pkg::MODE_SHIFT;
    end
  end

  // receiver
  logic [3:0]  rx_os_r, rx_cnt_r;
  logic [9:0]  rx_sh_r;
  logic [2:0]  vote_r;
  logic        rx_prev_r, rx_fin_r;
  wire  [3:0]  rx_bits = (mode_r == uart_pkg::MODE_8BIT) ? 4'd9 : 4'd10;
  wire         voted   = (vote_r[0] & vote_r[1]) | (vote_r[1] & vote_r[2]) | (vote_r[0] & vote_r[2]);  // R24
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_busy_r <= 1'b0;
      rx_os_r   <= 4'h0;
      rx_cnt_r  <= 4'h0;
      rx_sh_r   <= 10'h000;
      vote_r    <= 3'h7;
      rx_prev_r <= 1'b1;
      rx_fin_r  <= 1'b0;
    end else begin
      rx_fin_r  <= 1'b0;
      rx_prev_r <= rxd_in;
      if (!rx_busy_r) begin
        if (mode_r == uart_pkg::MODE_SHIFT) begin
          if (!ri_r && ren_r && !tx_busy_r) begin  // R03 R10
            rx_busy_r <= 1'b1;
            rx_cnt_r  <= 4'd8;
          end
        end else if (ren_r && rx_prev_r && !rxd_in) begin  // R04 R10
          rx_busy_r <= 1'b1;
          rx_os_r   <= 4'h0;
          rx_cnt_r  <= rx_bits;
        end
      end else if (mode_r == uart_pkg::MODE_SHIFT) begin
        if (bit_en && !txd_out) begin  // R19
          rx_sh_r  <= {2'b00, rxd_in, rx_sh_r[7:1]};
          rx_cnt_r <= rx_cnt_r - 4'h1;
          if (rx_cnt_r == 4'h1) begin
            rx_busy_r <= 1'b0;
            rx_fin_r  <= 1'b1;
          end
        end
      end else if (os_tick) begin
        rx_os_r <= rx_os_r + 4'h1;
        if (rx_os_r >= 4'd7 && rx_os_r <= 4'd9) vote_r <= {vote_r[1:0], rxd_in};
        if (rx_os_r == 4'd10) rx_sh_r <= {voted, rx_sh_r[9:1]};
        if (rx_os_r == 4'hf) begin
          rx_cnt_r <= rx_cnt_r - 4'h1;
          if (rx_cnt_r == 4'h0) begin
            rx_busy_r <= 1'b0;
            rx_fin_r  <= 1'b1;
          end
        end
      end
      // false start: start bit not held low at its centre
      if (rx_busy_r && mode_r != uart_pkg::MODE_SHIFT && os_tick && rx_os_r == 4'd10 &&
          rx_cnt_r == rx_bits && voted) begin
        rx_busy_r <= 1'b0;  // R24
      end
    end
  end

  // frame decode: align data, ninth bit and stop by frame length
  wire       is9      = mode_r[1];
  assign rx_byte      = (mode_r == uart_pkg::MODE_SHIFT) ? rx_sh_r[7:0] : is9 ? rx_sh_r[7:0] : rx_sh_r[8:1];
  assign rx_ninth     = is9 ? rx_sh_r[8] : rx_sh_r[9];
  wire       stop_ok  = rx_sh_r[9];
  // masked compare: mask bit 0 is don't care; all-ones byte is broadcast
  wire       match    = ((rx_byte & address_mask_r) == (own_address_r & address_mask_r))  // R15
                        || (rx_byte == 8'hff);
  wire       filt     = mp_r && (mode_r != uart_pkg::MODE_SHIFT);  // R18
  wire       pass     = !filt || (match && (is9 ? rx_ninth : stop_ok));  // R08 R09 R17
  assign rx_done      = rx_fin_r && pass;  // R14
  assign rx_fe_set    = rx_fin_r && (mode_r != uart_pkg::MODE_SHIFT) && !stop_ok;  // R05

  // interrupt request is the or of the two done flags
  always_ff @(posedge aclk) begin
    if (!aresetn) serial_irq <= 1'b0;
    else serial_irq <= ti_r | ri_r;  // R22
  end

  // assertions
  AST_IRQ_OR: assert property (@(posedge aclk) disable iff (!aresetn)  // R22
    serial_irq == $past(ti_r | ri_r)) else $error("irq not or of done flags");
  AST_TI_SET: assert property (@(posedge aclk) disable iff (!aresetn)  // R13
    tx_done |=> ti_r) else $error("tx done flag not set");
  AST_RI_SET: assert property (@(posedge aclk) disable iff (!aresetn)  // R14
    rx_done |=> ri_r) else $error("rx done flag not set");
  AST_FE_STICKY: assert property (@(posedge aclk) disable iff (!aresetn)  // R05
    fe_r && !ctrl_wr |=> fe_r) else $error("frame error cleared by hardware");
  AST_FE_SET: assert property (@(posedge aclk) disable iff (!aresetn)  // R05
    rx_fe_set |=> fe_r) else $error("frame error not set");
  AST_MP_FILT: assert property (@(posedge aclk) disable iff (!aresetn)  // R17
    rx_fin_r && filt && !match |-> !rx_done) else $error("unmatched byte raised receive done");
  AST_NOREN: assert property (@(posedge aclk) disable iff (!aresetn)  // R10
    !rx_busy_r && !ren_r |=> !rx_busy_r) else $error("reception with receive disabled");
  AST_TX_START: assert property (@(posedge aclk) disable iff (!aresetn)  // R02
    buf_wr && !tx_busy_r |=> tx_busy_r) else $error("write did not start tx");
  AST_ADDR_RW: assert property (@(posedge aclk) disable iff (!aresetn)  // R16
    wr_en && aw_addr_r == uart_pkg::ADDR_OFFS |=> own_address_r == $past(w_data_r))
    else $error("own address not written");
endmodule // uart_addr_recog_ctrl

// *** testbench/serial_node.sv ***
// behavioural remote serial node: sends frames to the device and decodes what it sends back
`timescale 1ns/10ps
module serial_node (
  input  wire logic       aclk,
  input  wire logic       line_in,
  input  wire logic       rx_wire,
  input  wire logic       async_en,
  input  wire logic       sync_en,
  input  wire logic       nine,
  input  wire logic [7:0] bit_clks,
  output logic            line_out,
  output logic [9:0]      got,
  output logic            got_stb
);
  logic [9:0] sh;
  logic [7:0] sh0;
  logic       prev_rx;

  initial begin
    line_out = 1'b1;  // idle at the mark level, as a pull-up leaves it
    got = 10'h000;
    got_stb = 1'b0;
  end

  // start 0, data lsb first, ninth bit in 9-bit modes, then stop; stop 0 forces a framing fault
  task automatic send(input logic [7:0] b, input logic b9, input logic stop);
    logic [10:0] f;
    f = nine ? {stop, b9, b, 1'b0} : {1'b1, stop, b, 1'b0};
    for (int i = 0; i < (nine ? 11 : 10); i++) begin
      line_out <= f[i];
      repeat (bit_clks) @(posedge aclk);
    end
    line_out <= 1'b1;
    repeat (8) @(posedge aclk);  // idle gap so the device closes its frame before a read back
  endtask

  // async listener: centre sampling; in 8-bit frames the stop fills both top slots
  always begin
    @(negedge line_in iff async_en);
    repeat (bit_clks / 2) @(posedge aclk);
    for (int i = 0; i < 10; i++) begin
      repeat (bit_clks) @(posedge aclk);
      sh[i] = line_in;
    end
    if (!nine) sh[9] = sh[8];
    got <= sh;
    got_stb <= 1'b1;
    @(posedge aclk);
    got_stb <= 1'b0;
  end

  // data level just before each clock edge, so a same-edge update cannot race the sample
  always @(negedge aclk) prev_rx <= rx_wire;

  // shift listener: one data bit per rising shift clock, lsb first
  always begin
    for (int i = 0; i < 8; i++) begin
      @(posedge line_in iff sync_en);
      sh0[i] = prev_rx;
    end
    got <= {2'b00, sh0};
    got_stb <= 1'b1;
    @(posedge aclk);
    got_stb <= 1'b0;
  end
endmodule  // serial_node

// *** testbench/tb_uart_addr_recog_ctrl.sv ***
// self-checking bench: axi4-lite register traffic and serial frames against the node model
`timescale 1ns/10ps
module tb_uart_addr_recog_ctrl;
  logic        aclk, aresetn, baud_tick, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, rxd_out, rxd_oe, txd_out, serial_irq;
  logic [7:0]  awaddr, araddr, v, m8;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp, tick_cnt;
  logic        node_line, got_stb, async_en, sync_en, nine;
  logic [7:0]  bit_clks;
  logic [9:0]  got;
  wire logic   rxd_in;
  logic [9:0]  rd_q[$];
  logic [7:0]  rm_q[$];
  logic [9:0]  fr_q[$];
  int          err_total, checked, i;
  // rows: control, byte, ninth or stop, receive-done expected
  logic [17:0] tbl [10] = '{{8'h70, 8'hc2, 2'b11}, {8'h70, 8'hc1, 2'b10}, {8'hf0, 8'hc2, 2'b11},
                            {8'hf0, 8'hc0, 2'b11}, {8'hf0, 8'hc2, 2'b00}, {8'hf0, 8'hc1, 2'b10},
                            {8'hf0, 8'hff, 2'b11}, {8'hb0, 8'hc2, 2'b11}, {8'h40, 8'h33, 2'b10},
                            {8'hd0, 8'h5a, 2'b01}};
  // transmit configs: control, power control, bit length in clocks
  logic [23:0] txc [3] = '{24'h980040, 24'hd00040, 24'h988020};

  assign rxd_in = rxd_oe ? rxd_out : node_line;  // device drives the line only in shift mode

  uart_addr_recog_ctrl uut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .baud_tick(baud_tick),
    .rxd_in(rxd_in), .rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd_out(txd_out), .serial_irq(serial_irq));

  serial_node node (
    .aclk(aclk), .line_in(txd_out), .rx_wire(rxd_in), .async_en(async_en), .sync_en(sync_en),
    .nine(nine), .bit_clks(bit_clks), .line_out(node_line), .got(got), .got_stb(got_stb));

  always #2.5 aclk = ~aclk;

  // one tick every 4 clocks gives 64-clock bits, the same as the fixed rate without doubler
  always @(posedge aclk) begin
    tick_cnt <= tick_cnt + 2'd1;
    baud_tick <= (tick_cnt == 2'd3);
  end

  task automatic check(input logic [9:0] seen, input logic [9:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    if (err_total == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // handshakes judged at the rising edge; each channel released right after its taking edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid && bready));
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [1:0] rs, input logic [7:0] e, input logic [7:0] m);
    @(posedge aclk);
    rd_q.push_back({rs, e & m});
    rm_q.push_back(m);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid && rready));
    rready <= 1'b0;
  endtask

  // long tail so a frame that should never have started is still caught
  task automatic drain;
    for (int n = 0; n < 3000 && fr_q.size() > 0; n++) @(posedge aclk);
    repeat (700) @(posedge aclk);
  endtask

  // read answers judged at the falling edge before the taking edge against the oldest note
  always @(negedge aclk) begin
    if (rvalid && rready) begin
      m8 = rm_q.pop_front();
      check({rresp, rdata[7:0] & m8}, rd_q.pop_front());
    end
  end

  // frames decoded by the node judged against the oldest note
  always @(posedge got_stb) begin
    if (fr_q.size() == 0) check(10'h001, 10'h000);
    else check(got, fr_q.pop_front());
  end

  initial begin
    #300000;
    err_total++;
    tally_and_finish;
  end

  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    baud_tick = 1'b0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    tick_cnt = 2'b00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0000_0000;
    sync_en = 1'b0;
    nine = 1'b0;
    err_total = 0;
    checked = 0;
    async_en = 1'b1;
    bit_clks = 8'd64;
    v = 8'($urandom(32'h8e70));
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(uart_pkg::CTRL_OFFS, 2'b00, uart_pkg::CTRL_RST, 8'hff);
    wr(uart_pkg::ADDR_OFFS, v);
    rd(uart_pkg::ADDR_OFFS, 2'b00, v, 8'hff);
    wr(uart_pkg::MASK_OFFS, ~v);
    rd(uart_pkg::MASK_OFFS, 2'b00, ~v, 8'hff);
    rd(8'h1c, 2'b10, 8'h00, 8'hff);
    // 8-bit transmit; a second write while busy must be dropped
    wr(uart_pkg::CTRL_OFFS, 8'h50);
    v = 8'($urandom());
    fr_q.push_back({2'b11, v});
    wr(uart_pkg::BUF_OFFS, v);
    wr(uart_pkg::BUF_OFFS, ~v);
    drain;
    rd(uart_pkg::CTRL_OFFS, 2'b00, 8'h02, 8'h02);
    check(serial_irq, 1'b1);
    wr(uart_pkg::CTRL_OFFS, 8'h50);
    repeat (2) @(posedge aclk);
    check(serial_irq, 1'b0);
    // 8-bit receive, stop bit lands in the ninth-bit field
    v = 8'($urandom());
    node.send(v, 1'b0, 1'b1);
    rd(uart_pkg::BUF_OFFS, 2'b00, v, 8'hff);
    rd(uart_pkg::CTRL_OFFS, 2'b00, 8'h05, 8'h05);
    // framing fault sticks through a good frame until software clears it
    wr(uart_pkg::CTRL_OFFS, 8'h50);
    node.send(v, 1'b0, 1'b0);
    wr(uart_pkg::PWR_OFFS, 8'h40);
    rd(uart_pkg::CTRL_OFFS, 2'b00, 8'h80, 8'h80);
    node.send(v, 1'b0, 1'b1);
    rd(uart_pkg::CTRL_OFFS, 2'b00, 8'h80, 8'h80);
    wr(uart_pkg::CTRL_OFFS, 8'h50);
    rd(uart_pkg::CTRL_OFFS, 2'b00, 8'h50, 8'hd0);
    wr(uart_pkg::PWR_OFFS, 8'h00);
    rd(uart_pkg::CTRL_OFFS, 2'b00, 8'h50, 8'hf0);
    // address filter: compare pattern 110000x0, broadcast, ninth bit, receive enable
    wr(uart_pkg::ADDR_OFFS, 8'hc0);
    wr(uart_pkg::MASK_OFFS, 8'hfd);
    for (i = 0; i < 10; i++) begin
      wr(uart_pkg::CTRL_OFFS, tbl[i][17:10]);
      nine = tbl[i][17];
      node.send(tbl[i][9:2], tbl[i][1], tbl[i][1] | tbl[i][17]);
      rd(uart_pkg::CTRL_OFFS, 2'b00, {5'h0, tbl[i][1], 1'b0, tbl[i][0]}, tbl[i][0] ? 8'h05 : 8'h01);
    end
    // 9-bit transmit in fixed and variable rate, then with the doubler
    for (i = 0; i < 3; i++) begin
      bit_clks = txc[i][7:0];
      wr(uart_pkg::PWR_OFFS, txc[i][15:8]);
      wr(uart_pkg::CTRL_OFFS, txc[i][23:16]);
      v = 8'($urandom());
      fr_q.push_back({1'b1, txc[i][19], v});
      wr(uart_pkg::BUF_OFFS, v);
      drain;
    end
    // shift mode: transmit, then reception that starts by itself
    wr(uart_pkg::PWR_OFFS, 8'h00);
    async_en = 1'b0;
    sync_en = 1'b1;
    wr(uart_pkg::CTRL_OFFS, 8'h00);
    v = 8'($urandom());
    fr_q.push_back({2'b00, v});
    wr(uart_pkg::BUF_OFFS, v);
    drain;
    sync_en = 1'b0;
    wr(uart_pkg::CTRL_OFFS, 8'h10);
    repeat (300) @(posedge aclk);
    rd(uart_pkg::BUF_OFFS, 2'b00, 8'hff, 8'hff);
    rd(uart_pkg::CTRL_OFFS, 2'b00, 8'h01, 8'h01);
    tally_and_finish;
  end
endmodule  // tb_uart_addr_recog_ctrl
